// file: pwd_pkg.sv
package pwd_pkg;
  // register addresses
  localparam logic [7:0] ADDR_MISC_OPT2  = 8'h7c;
  localparam logic [7:0] ADDR_WDT_CTRL   = 8'ha0;
  localparam logic [7:0] ADDR_SLOW_TIME  = 8'ha1;
  localparam logic [7:0] ADDR_FAST_TIME  = 8'ha2;
  localparam logic [7:0] ADDR_KICK       = 8'ha3;
  localparam logic [7:0] ADDR_PIN_CTRL   = 8'ha4;
  localparam logic [7:0] ADDR_RST_CTRL   = 8'ha5;
  localparam logic [7:0] ADDR_RST_ROUTE  = 8'ha6;
  localparam logic [7:0] ADDR_WDT_STAT   = 8'ha7;
  // field positions
  localparam int PIN_WDATA_BIT   = 0;
  localparam int PIN_DIR_BIT     = 1;
  localparam int PIN_FN_LSB      = 2;
  localparam int PIN_LEVEL_BIT   = 7;
  localparam int RST_SW_BIT      = 3;
  localparam int SHORT_PULSE_BIT = 3;
  localparam int WDT_EN_BIT      = 0;
  localparam int WDT_MASK_LSB    = 1;
  localparam int KSEL_GPIO_BIT   = 4;
  localparam int KSEL_I2C_BIT    = 5;
  localparam int SHUT_LV_BIT     = 6;
  localparam int LOCK_BIT        = 7;
  localparam int TICK_LSB        = 6;
  localparam int CNT_W           = 6;
  localparam int ROUTE_SEQ_BIT   = 3;
  localparam int PG_IGN_LSB      = 4;
  localparam int SEQ_ORDER_BIT   = 6;
  // reset values and write masks
  localparam logic [7:0] PIN_CTRL_RST   = 8'h04;
  localparam logic [7:0] PIN_CTRL_WMASK = 8'h0f;
  localparam logic [7:0] CFG_RST        = 8'h00;
  // pin functions
  localparam logic [1:0] FN_LOGIC = 2'h0;
  localparam logic [1:0] FN_INIT  = 2'h1;
  localparam logic [1:0] FN_FAULT = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_LONG_MS      = 200;
  localparam int T_SHORT_MS     = 20;
  localparam int T_TICK0_US     = 100;
  localparam int T_TICK1_MS     = 1;
  localparam int T_TICK2_MS     = 10;
  localparam int T_TICK3_MS     = 100;
  localparam int LONG_CYC  = T_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SHORT_CYC = T_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK0_CYC = T_TICK0_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK1_CYC = T_TICK1_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK2_CYC = T_TICK2_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK3_CYC = T_TICK3_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PWD_WDT_IDLE    = 3'b001,
    PWD_WDT_RESTART = 3'b010,
    PWD_WDT_RUN     = 3'b100
  } pwd_wdt_state_t;
endpackage : pwd_pkg

// file: pwd_pulse_gen.sv
`timescale 1ns/1ps
module pwd_pulse_gen #(
  parameter int unsigned LONG_CYC  = 4000000,
  parameter int unsigned SHORT_CYC = 400000,
  parameter int          CNT_W     = 22
) (
  input  logic ref_clk_i,
  input  logic rstn_i,
  input  logic long_i,
  input  logic short_i,
  output logic rstn_o
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             out_r, out_nxt;

  // a retrigger never shortens a pulse already running
  always_comb begin
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    if (long_i) begin
      cnt_nxt = CNT_W'(LONG_CYC); // R12
    end else if (short_i && cnt_r < CNT_W'(SHORT_CYC)) begin
      cnt_nxt = CNT_W'(SHORT_CYC); // R12
    end
    out_nxt = (cnt_nxt == '0);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      out_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign rstn_o = out_r;

  a_long_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    long_i |=> (cnt_r == CNT_W'(LONG_CYC)) && !rstn_o) // R12
    else $error("long pulse not loaded");
  a_pulse_end: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (cnt_r == CNT_W'(1) && !long_i && !short_i) |=> rstn_o) // R12
    else $error("pulse did not end");
endmodule : pwd_pulse_gen

// file: pwd_wdt_timer.sv
`timescale 1ns/1ps
module pwd_wdt_timer #(
  parameter int unsigned TICK0_CYC = 2000,
  parameter int unsigned TICK1_CYC = 20000,
  parameter int unsigned TICK2_CYC = 200000,
  parameter int unsigned TICK3_CYC = 2000000,
  parameter int          PRE_W     = 22
) (
  input  logic                     ref_clk_i,
  input  logic                     rstn_i,
  input  logic                     kick_i,
  input  logic [1:0]               tick_s_i,
  input  logic [pwd_pkg::CNT_W-1:0] cnt_s_i,
  input  logic [1:0]               tick_f_i,
  input  logic [pwd_pkg::CNT_W-1:0] cnt_f_i,
  output logic [2:0]               flt_o
);
  localparam int EW = pwd_pkg::CNT_W + 1;

  function automatic logic [PRE_W-1:0] tick_last(input logic [1:0] sel);
    case (sel)
      2'h0:    tick_last = PRE_W'(TICK0_CYC - 1);
      2'h1:    tick_last = PRE_W'(TICK1_CYC - 1);
      2'h2:    tick_last = PRE_W'(TICK2_CYC - 1);
      default: tick_last = PRE_W'(TICK3_CYC - 1);
    endcase
  endfunction : tick_last

  pwd_pkg::pwd_wdt_state_t st_r, st_nxt;
  logic [PRE_W-1:0] pre_s_r, pre_s_nxt, pre_f_r, pre_f_nxt;
  logic [EW-1:0]    el_s_r, el_s_nxt, el_f_r, el_f_nxt, slow_lim;
  logic [2:0]       flt_r, flt_nxt;
  logic             restart;

  always_comb begin
    restart  = 1'b0;
    flt_nxt  = 3'h0;
    st_nxt   = st_r;
    // restart window is twice the slow interval
    slow_lim = (st_r == pwd_pkg::PWD_WDT_RESTART) ? {cnt_s_i, 1'b0}
                                                  : {1'b0, cnt_s_i}; // R16
    pre_s_nxt = (pre_s_r == tick_last(tick_s_i)) ? '0 : pre_s_r + 1'b1;
    pre_f_nxt = (pre_f_r == tick_last(tick_f_i)) ? '0 : pre_f_r + 1'b1;
    el_s_nxt  = el_s_r;
    el_f_nxt  = el_f_r;
    if (pre_s_r == tick_last(tick_s_i) && !(&el_s_r)) el_s_nxt = el_s_r + 1'b1;
    if (pre_f_r == tick_last(tick_f_i) && !(&el_f_r)) el_f_nxt = el_f_r + 1'b1;
    case (st_r)
      pwd_pkg::PWD_WDT_IDLE: begin
        if (kick_i && cnt_s_i != '0) begin
          st_nxt = pwd_pkg::PWD_WDT_RESTART; // R17
        end
        restart = kick_i;
      end
      pwd_pkg::PWD_WDT_RESTART, pwd_pkg::PWD_WDT_RUN: begin
        if (cnt_s_i == '0) begin
          st_nxt = pwd_pkg::PWD_WDT_IDLE;
        end else if (kick_i) begin
          restart = 1'b1;
          if (cnt_f_i != '0 && el_f_r < {1'b0, cnt_f_i}) begin
            flt_nxt[2] = 1'b1; // R24
            st_nxt     = pwd_pkg::PWD_WDT_RESTART;
          end else begin
            st_nxt = pwd_pkg::PWD_WDT_RUN;
          end
        end else if (el_s_r >= slow_lim) begin
          restart = 1'b1;
          flt_nxt[0] = (st_r == pwd_pkg::PWD_WDT_RESTART); // R16
          flt_nxt[1] = (st_r == pwd_pkg::PWD_WDT_RUN); // R15
          st_nxt     = pwd_pkg::PWD_WDT_RESTART;
        end
      end
      default: st_nxt = pwd_pkg::PWD_WDT_IDLE;
    endcase
    if (restart) begin
      pre_s_nxt = '0;
      pre_f_nxt = '0;
      el_s_nxt  = '0;
      el_f_nxt  = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r    <= pwd_pkg::PWD_WDT_IDLE;
      pre_s_r <= '0;
      pre_f_r <= '0;
      el_s_r  <= '0;
      el_f_r  <= '0;
      flt_r   <= 3'h0;
    end else begin
      st_r    <= st_nxt;
      pre_s_r <= pre_s_nxt;
      pre_f_r <= pre_f_nxt;
      el_s_r  <= el_s_nxt;
      el_f_r  <= el_f_nxt;
      flt_r   <= flt_nxt;
    end
  end

  assign flt_o = flt_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_arm_kick: assert property (st_r == pwd_pkg::PWD_WDT_IDLE && kick_i && // R17
    cnt_s_i != '0 |=> st_r == pwd_pkg::PWD_WDT_RESTART)
    else $error("watchdog did not arm on kick");
  a_fast_kick: assert property (st_r != pwd_pkg::PWD_WDT_IDLE && // R24
    kick_i && cnt_s_i != '0 && cnt_f_i != '0 && el_f_r < {1'b0, cnt_f_i}
    |=> flt_o[2])
    else $error("early kick not flagged");
  a_slow_timeout: assert property (st_r == pwd_pkg::PWD_WDT_RUN && // R15
    !kick_i && cnt_s_i != '0 && el_s_r >= {1'b0, cnt_s_i} |=>
    flt_o[1] && !flt_o[0])
    else $error("slow timeout not flagged");
  a_restart_2x: assert property (st_r == pwd_pkg::PWD_WDT_RESTART && // R16
    !kick_i && cnt_s_i != '0 && el_s_r < {cnt_s_i, 1'b0} |=> !flt_o[0])
    else $error("restart fault before twice the interval");
endmodule : pwd_wdt_timer

// file: pwd_top.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - pin level readable in control bit 7
// R2 - logic output drives the write-data level
// R3 - pin is always open-drain
// R4 - reset function: released, low after init
// R5 - host changes pin setup only after init; the code accepts pin control writes at any time
// R6 - input direction overrides pin function
// R7 - power-good loss pulses fault reset low
// R8 - ignore option drops last outputs of sequence
// R9 - high-voltage power-good is never ignored
// R10 - watchdog or sequence fault may pulse reset
// R11 - shutdown faults pulse reset at once
// R12 - reset pulse 200ms, optional 20ms
// R13 - short pulse select in option bit 3
// R14 - three watchdog faults, each with mask
// R15 - slow interval is tick times count
// R16 - restart fault uses twice slow interval
// R17 - arm on first kick, set status
// R18 - disabled watchdog records but never shuts down
// R19 - kicks from pin, register, or both
// R20 - shutdown all outputs or low-voltage only
// R21 - lockout freezes watchdog settings until reset
// R22 - write bit 3 gives one reset pulse
// R23 - status bits stick until cleared
// R24 - early kick raises too-fast fault
module pwd_top #(
  parameter int unsigned LONG_CYC  = pwd_pkg::LONG_CYC,
  parameter int unsigned SHORT_CYC = pwd_pkg::SHORT_CYC,
  parameter int unsigned TICK0_CYC = pwd_pkg::TICK0_CYC,
  parameter int unsigned TICK1_CYC = pwd_pkg::TICK1_CYC,
  parameter int unsigned TICK2_CYC = pwd_pkg::TICK2_CYC,
  parameter int unsigned TICK3_CYC = pwd_pkg::TICK3_CYC
) (
  input  logic       ref_clk_i,
  input  logic       rstn_i,
  input  logic       reg_wr_i,
  input  logic       reg_rd_i,
  input  logic [7:0] reg_addr_i,
  input  logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input  logic [3:0] power_good_i,
  input  logic       init_done_i,
  input  logic       seq_fault_i,
  input  logic       shutdown_fault_i,
  input  logic       gpio_pin_i,
  output logic       gpio_pin_o,
  output logic       gpio_pin_oe_o,
  output logic       fault_rstn_o,
  output logic       wdt_shut_all_o,
  output logic       wdt_shut_lv_o
);
  // power_good_i: 0 hv output, 1 lv buck a, 2 lv buck b, 3 lv linear
  function automatic logic [2:0] ign_mask(input logic [1:0] opt,
                                          input logic       order);
    case (opt)
      2'h0:    ign_mask = 3'h0;
      2'h1:    ign_mask = order ? 3'h2 : 3'h4;
      2'h2:    ign_mask = order ? 3'h3 : 3'h6;
      default: ign_mask = 3'h7;
    endcase
  endfunction : ign_mask

  logic [7:0] misc2_r, misc2_nxt;
  logic [7:0] pin_ctrl_r, pin_ctrl_nxt;
  logic [7:0] wdt_ctrl_r, wdt_ctrl_nxt;
  logic [7:0] slow_r, slow_nxt;
  logic [7:0] fast_r, fast_nxt;
  logic [7:0] route_r, route_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [4:0] sync1_r, sync2_r;
  logic       pin_d_r;
  logic [3:0] pg_bad_r;
  logic       seq_d_r, shut_d_r;
  logic       oe_r, oe_nxt;
  logic       gpio_out_r;
  logic       shut_all_r, shut_all_nxt;
  logic       shut_lv_r, shut_lv_nxt;

  logic       locked, pin_level, pin_rise, kick, wdt_hit;
  logic [2:0] wdt_flt, stat_clr;
  logic [3:0] pg_bad;
  logic       pg_new, route_hit, sw_pulse, short_sel;
  logic       long_trig, short_trig;
  logic [1:0] pin_fn;

  assign locked    = wdt_ctrl_r[pwd_pkg::LOCK_BIT];
  assign pin_level = sync2_r[4];
  assign pin_rise  = sync2_r[4] && !pin_d_r;
  assign pin_fn    = pin_ctrl_r[pwd_pkg::PIN_FN_LSB +: 2];
  assign stat_clr  = (reg_wr_i && reg_addr_i == pwd_pkg::ADDR_WDT_STAT)
                     ? reg_wdata_i[2:0] : 3'h0;
  assign sw_pulse  = reg_wr_i && reg_addr_i == pwd_pkg::ADDR_RST_CTRL &&
                     reg_wdata_i[pwd_pkg::RST_SW_BIT]; // R22
  assign short_sel = misc2_r[pwd_pkg::SHORT_PULSE_BIT]; // R13

  // kick sources as selected
  assign kick = (wdt_ctrl_r[pwd_pkg::KSEL_I2C_BIT] && reg_wr_i &&
                 reg_addr_i == pwd_pkg::ADDR_KICK) ||
                (wdt_ctrl_r[pwd_pkg::KSEL_GPIO_BIT] && pin_rise); // R19

  // hv power-good always counts; lv ones follow the ignore option
  assign pg_bad = ~sync2_r[3:0] &
                  {~ign_mask(route_r[pwd_pkg::PG_IGN_LSB +: 2],
                             route_r[pwd_pkg::SEQ_ORDER_BIT]), 1'b1}; // R8 R9
  assign pg_new = |(pg_bad & ~pg_bad_r); // R7

  assign route_hit = |(wdt_flt & route_r[2:0]) ||
                     (route_r[pwd_pkg::ROUTE_SEQ_BIT] &&
                      seq_fault_i && !seq_d_r); // R10
  // fault onsets only; a fault still present gives no second pulse
  assign long_trig  = pg_new || sw_pulse || (shutdown_fault_i && !shut_d_r) ||
                      (route_hit && !short_sel); // R7 R11 R12
  assign short_trig = route_hit && short_sel; // R12

  assign wdt_hit = wdt_ctrl_r[pwd_pkg::WDT_EN_BIT] && // R14 R18
                   |(wdt_flt & wdt_ctrl_r[pwd_pkg::WDT_MASK_LSB +: 3]);

  // register file
  always_comb begin
    misc2_nxt    = misc2_r;
    pin_ctrl_nxt = pin_ctrl_r;
    wdt_ctrl_nxt = wdt_ctrl_r;
    slow_nxt     = slow_r;
    fast_nxt     = fast_r;
    route_nxt    = route_r;
    rdata_nxt    = rdata_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        pwd_pkg::ADDR_MISC_OPT2: misc2_nxt = reg_wdata_i;
        pwd_pkg::ADDR_PIN_CTRL:
          pin_ctrl_nxt = reg_wdata_i & pwd_pkg::PIN_CTRL_WMASK;
        pwd_pkg::ADDR_WDT_CTRL: if (!locked) wdt_ctrl_nxt = reg_wdata_i; // R21
        pwd_pkg::ADDR_SLOW_TIME: if (!locked) slow_nxt = reg_wdata_i; // R21
        pwd_pkg::ADDR_FAST_TIME: if (!locked) fast_nxt = reg_wdata_i; // R21
        pwd_pkg::ADDR_RST_ROUTE:
          route_nxt = locked ? {reg_wdata_i[7:3], route_r[2:0]}
                             : reg_wdata_i; // R21
        default: ;
      endcase
    end
    // a fault in the clearing cycle stays set
    stat_nxt = (stat_r & ~stat_clr) | wdt_flt; // R17 R23
    if (reg_rd_i) begin
      case (reg_addr_i)
        pwd_pkg::ADDR_MISC_OPT2: rdata_nxt = misc2_r;
        pwd_pkg::ADDR_WDT_CTRL:  rdata_nxt = wdt_ctrl_r;
        pwd_pkg::ADDR_SLOW_TIME: rdata_nxt = slow_r;
        pwd_pkg::ADDR_FAST_TIME: rdata_nxt = fast_r;
        pwd_pkg::ADDR_PIN_CTRL:  rdata_nxt = {pin_level, pin_ctrl_r[6:0]}; // R1
        pwd_pkg::ADDR_RST_ROUTE: rdata_nxt = route_r;
        pwd_pkg::ADDR_WDT_STAT:  rdata_nxt = {5'h00, stat_r};
        default:                 rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      misc2_r    <= pwd_pkg::CFG_RST;
      pin_ctrl_r <= pwd_pkg::PIN_CTRL_RST; // R4
      wdt_ctrl_r <= pwd_pkg::CFG_RST;
      slow_r     <= pwd_pkg::CFG_RST;
      fast_r     <= pwd_pkg::CFG_RST;
      route_r    <= pwd_pkg::CFG_RST;
      stat_r     <= 3'h0;
      rdata_r    <= 8'h00;
    end else begin
      misc2_r    <= misc2_nxt;
      pin_ctrl_r <= pin_ctrl_nxt;
      wdt_ctrl_r <= wdt_ctrl_nxt;
      slow_r     <= slow_nxt;
      fast_r     <= fast_nxt;
      route_r    <= route_nxt;
      stat_r     <= stat_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // pin driver and shutdown requests
  always_comb begin
    if (pin_ctrl_r[pwd_pkg::PIN_DIR_BIT]) begin
      oe_nxt = 1'b0; // R6
    end else begin
      case (pin_fn)
        pwd_pkg::FN_LOGIC: oe_nxt = !pin_ctrl_r[pwd_pkg::PIN_WDATA_BIT]; // R2
        pwd_pkg::FN_INIT:  oe_nxt = init_done_i; // R4
        pwd_pkg::FN_FAULT: oe_nxt = |stat_r;
        default:           oe_nxt = !pin_ctrl_r[pwd_pkg::PIN_WDATA_BIT];
      endcase
    end
    shut_all_nxt = wdt_hit && !wdt_ctrl_r[pwd_pkg::SHUT_LV_BIT]; // R20
    shut_lv_nxt  = wdt_hit && wdt_ctrl_r[pwd_pkg::SHUT_LV_BIT]; // R20
  end

  // pin and power-good inputs are asynchronous, two flops first
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r    <= 5'h1f;
      sync2_r    <= 5'h1f;
      pin_d_r    <= 1'b1;
      pg_bad_r   <= 4'h0;
      seq_d_r    <= 1'b0;
      shut_d_r   <= 1'b0;
      oe_r       <= 1'b0;
      gpio_out_r <= 1'b0;
      shut_all_r <= 1'b0;
      shut_lv_r  <= 1'b0;
    end else begin
      sync1_r    <= {gpio_pin_i, power_good_i};
      sync2_r    <= sync1_r;
      pin_d_r    <= sync2_r[4];
      pg_bad_r   <= pg_bad;
      seq_d_r    <= seq_fault_i;
      shut_d_r   <= shutdown_fault_i;
      oe_r       <= oe_nxt;
      gpio_out_r <= 1'b0; // R3
      shut_all_r <= shut_all_nxt;
      shut_lv_r  <= shut_lv_nxt;
    end
  end

  assign reg_rdata_o    = rdata_r;
  assign gpio_pin_o     = gpio_out_r;
  assign gpio_pin_oe_o  = oe_r;
  assign wdt_shut_all_o = shut_all_r;
  assign wdt_shut_lv_o  = shut_lv_r;

  pwd_wdt_timer #(
    .TICK0_CYC (TICK0_CYC),
    .TICK1_CYC (TICK1_CYC),
    .TICK2_CYC (TICK2_CYC),
    .TICK3_CYC (TICK3_CYC)
  ) u_wdt (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .kick_i    (kick),
    .tick_s_i  (slow_r[pwd_pkg::TICK_LSB +: 2]),
    .cnt_s_i   (slow_r[pwd_pkg::CNT_W-1:0]),
    .tick_f_i  (fast_r[pwd_pkg::TICK_LSB +: 2]),
    .cnt_f_i   (fast_r[pwd_pkg::CNT_W-1:0]),
    .flt_o     (wdt_flt)
  );

  pwd_pulse_gen #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC),
    .CNT_W     ($clog2(LONG_CYC + 1))
  ) u_pulse (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .long_i    (long_trig),
    .short_i   (short_trig),
    .rstn_o    (fault_rstn_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_pin_level: assert property (reg_rd_i && // R1
    reg_addr_i == pwd_pkg::ADDR_PIN_CTRL |=>
    reg_rdata_o[7] == $past(pin_level))
    else $error("pin level not reflected");
  a_open_drain: assert property (!gpio_pin_o) // R3
    else $error("pin driven high");
  a_input_dir: assert property (pin_ctrl_r[pwd_pkg::PIN_DIR_BIT] // R6
    |=> !gpio_pin_oe_o)
    else $error("input pin driven");
  a_init_fn: assert property (!pin_ctrl_r[pwd_pkg::PIN_DIR_BIT] && // R4
    pin_fn == pwd_pkg::FN_INIT |=> gpio_pin_oe_o == $past(init_done_i))
    else $error("init function wrong");
  a_pg_fault: assert property (pg_new |=> !fault_rstn_o) // R7
    else $error("power-good loss gave no pulse");
  a_hv_never: assert property (!sync2_r[0] && !pg_bad_r[0] // R9
    |=> !fault_rstn_o)
    else $error("hv power-good loss ignored");
  a_sw_pulse: assert property (sw_pulse |=> !fault_rstn_o) // R22
    else $error("software pulse missing");
  a_shut_gate: assert property (!wdt_ctrl_r[pwd_pkg::WDT_EN_BIT] // R18
    |=> !wdt_shut_all_o && !wdt_shut_lv_o)
    else $error("disabled watchdog shut outputs");
  a_lock_hold: assert property (locked && reg_wr_i && // R21
    reg_addr_i == pwd_pkg::ADDR_SLOW_TIME |=> $stable(slow_r))
    else $error("locked setting changed");
  a_sticky: assert property (stat_r[1] && !stat_clr[1] |=> stat_r[1]) // R23
    else $error("status bit lost");
endmodule : pwd_top

// file: pwd_mcu_model.sv
`timescale 1ns/1ps
module pwd_mcu_model (
  input  wire logic pin_oe_i,
  input  wire logic pin_o_i,
  input  wire logic pull_low_i,
  output logic      pin_lvl_o
);
  // open-drain wire with pull-up; whoever pulls low wins
  assign pin_lvl_o = !((pin_oe_i && !pin_o_i) || pull_low_i);
endmodule : pwd_mcu_model

// file: pwd_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module pwd_top_bench;
  localparam int LC = 40;
  localparam int SC = 8;
  localparam logic [7:0] A_PIN  = pwd_pkg::ADDR_PIN_CTRL;
  localparam logic [7:0] A_RTE  = pwd_pkg::ADDR_RST_ROUTE;
  localparam logic [7:0] A_CTL  = pwd_pkg::ADDR_WDT_CTRL;
  localparam logic [7:0] A_SLOW = pwd_pkg::ADDR_SLOW_TIME;
  localparam logic [7:0] A_STAT = pwd_pkg::ADDR_WDT_STAT;
  logic       ref_clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic [3:0] pg = 4'hf;
  logic       init_done = 1'b0;
  logic       seq_f = 1'b0;
  logic       shut_f = 1'b0;
  logic       mcu_low = 1'b0;
  logic       pin_lvl;
  logic       pin_o;
  logic       pin_oe;
  logic       frst_n;
  logic       sh_all;
  logic       sh_lv;
  int         fails = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         n_shut = 0;

  pwd_top #(.LONG_CYC(LC), .SHORT_CYC(SC), .TICK0_CYC(4), .TICK1_CYC(6),
    .TICK2_CYC(8), .TICK3_CYC(10)) i_pwd_top (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_rdata_o(rdat), .power_good_i(pg), .init_done_i(init_done),
    .seq_fault_i(seq_f), .shutdown_fault_i(shut_f), .gpio_pin_i(pin_lvl),
    .gpio_pin_o(pin_o), .gpio_pin_oe_o(pin_oe), .fault_rstn_o(frst_n),
    .wdt_shut_all_o(sh_all), .wdt_shut_lv_o(sh_lv));
  pwd_mcu_model i_pwd_mcu_model (.pin_oe_i(pin_oe), .pin_o_i(pin_o),
    .pull_low_i(mcu_low), .pin_lvl_o(pin_lvl));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // run is well under 3000 cycles; a hang is cut at 20000
  always @(posedge ref_clk_i) begin
    cyc++;
    if (sh_all === 1'b1 || sh_lv === 1'b1) n_shut++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    wr_s = 1'b1;
    addr = a;
    wdat = d;
    @(negedge ref_clk_i);
    wr_s = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    rd_s = 1'b1;
    addr = a;
    @(negedge ref_clk_i);
    rd_s = 1'b0;
    d = rdat;
  endtask : rd

  // width of the next low pulse, 0 when none starts within 12 cycles
  task automatic pulse(input string nm, input int e);
    int n;
    n = 0;
    repeat (12) if (frst_n === 1'b1) @(negedge ref_clk_i);
    while (frst_n === 1'b0 && n < 999) begin
      n++;
      @(negedge ref_clk_i);
    end
    `CHK(nm, e, n)
  endtask : pulse

  task automatic wait_sh(input logic lv, output int n);
    n = 0;
    while ((lv ? sh_lv : sh_all) !== 1'b1 && n < 200) begin
      n++;
      @(negedge ref_clk_i);
    end
  endtask : wait_sh

  task automatic t_pin;
    logic [7:0] d;
    rd(A_PIN, d);
    `CHK("pin rst", 8'h84, d)
    init_done = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rd(A_PIN, d);
    `CHK("pin init", 8'h04, d)
    `CHK("pin od", 1'b0, pin_o)
    wr(A_PIN, 8'h01);
    repeat (4) @(negedge ref_clk_i);
    rd(A_PIN, d);
    `CHK("pin wdata", 8'h81, d)
    wr(A_PIN, 8'h03);
    mcu_low = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rd(A_PIN, d);
    `CHK("pin input", 8'h03, d)
    `CHK("pin in oe", 1'b0, pin_oe)
    mcu_low = 1'b0;
    $display("done t_pin");
  endtask : t_pin

  task automatic t_pulses;
    wr(pwd_pkg::ADDR_RST_CTRL, 8'h08);
    pulse("sw", LC);
    pulse("sw once", 0);
    wr(A_RTE, 8'h30);
    pg = 4'he;
    pulse("pg hv", LC);
    pg = 4'hf;
    wr(A_RTE, 8'h10);
    pg = 4'h7;
    pulse("pg lin ign", 0);
    pg = 4'hb;
    pulse("pg b", LC);
    pg = 4'hf;
    wr(A_RTE, 8'h50);
    pg = 4'hb;
    pulse("pg b ign", 0);
    pg = 4'hf;
    wr(pwd_pkg::ADDR_MISC_OPT2, 8'h08);
    wr(A_RTE, 8'h08);
    seq_f = 1'b1;
    pulse("seq short", SC);
    seq_f = 1'b0;
    shut_f = 1'b1;
    pulse("shut fault", LC);
    shut_f = 1'b0;
    wr(A_RTE, 8'h00);
    seq_f = 1'b1;
    pulse("seq off", 0);
    seq_f = 1'b0;
    $display("done t_pulses");
  endtask : t_pulses

  task automatic t_wdt;
    logic [7:0] d;
    int         n;
    wr(A_RTE, 8'h01);
    wr(A_SLOW, 8'hc2);
    wr(A_CTL, 8'h1f);
    mcu_low = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    mcu_low = 1'b0;
    // tick phase is set by the arming kick; allow one tick of slack
    wait_sh(1'b0, n);
    `CHK("restart time", 1'b1, n >= 35 && n <= 52)
    `CHK("restart lv", 1'b0, sh_lv)
    rd(A_STAT, d);
    `CHK("restart stat", 8'h01, d)
    wr(A_STAT, 8'h01);
    rd(A_STAT, d);
    `CHK("stat clear", 8'h00, d)
    wr(pwd_pkg::ADDR_FAST_TIME, 8'hc2);
    wr(A_CTL, 8'h6f);
    wr(pwd_pkg::ADDR_KICK, 8'h00);
    wr(pwd_pkg::ADDR_KICK, 8'h00);
    wait_sh(1'b1, n);
    `CHK("fast lv", 1'b1, n <= 4)
    rd(A_STAT, d);
    `CHK("fast stat", 8'h04, d & 8'h04)
    // kick past the fast window, inside the restart limit
    repeat (30) @(negedge ref_clk_i);
    wr(pwd_pkg::ADDR_KICK, 8'h00);
    wait_sh(1'b1, n);
    `CHK("slow time", 1'b1, n >= 18 && n <= 24)
    rd(A_STAT, d);
    `CHK("slow stat", 8'h02, d & 8'h03)
    $display("done t_wdt");
  endtask : t_wdt

  task automatic t_lock;
    logic [7:0] d;
    int         m;
    wr(A_CTL, 8'h80);
    wr(A_CTL, 8'h2f);
    wr(A_SLOW, 8'h01);
    rd(A_CTL, d);
    `CHK("lock ctl", 8'h80, d)
    rd(A_SLOW, d);
    `CHK("lock slow", 8'hc2, d)
    wr(A_STAT, 8'h07);
    m = n_shut;
    repeat (120) @(negedge ref_clk_i);
    rd(A_STAT, d);
    `CHK("off record", 8'h01, d & 8'h01)
    `CHK("off quiet", m, n_shut)
    wr(A_PIN, 8'h08);
    @(negedge ref_clk_i);
    `CHK("pin flt oe", 1'b1, pin_oe)
    `CHK("pin flt lvl", 1'b0, pin_lvl)
    $display("done t_lock");
  endtask : t_lock

  initial begin
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_pin();
    t_pulses();
    t_wdt();
    t_lock();
    wrap_up();
  end
endmodule : pwd_top_bench
